// >>> core/drive_ident_bank.v
// identification and monitoring parameter bank of the drive
// assumes a fieldbus stack that issues one parameter request per pulse on clk_sys
`timescale 1ns/100ps
`default_nettype none
`include "drive_ident_defines.vh"

// How it works
// RL1: communication module program number reads as decimal of its digits.
// RL2: device firmware number reads as decimal of its digits, same encoding.
// RL3: communication module firmware version reads as decimal of its digits.
// RL4: device firmware version reads as decimal of its digits.
// RL5: 32-bit persistent serial number, full unsigned range, identifies the unit.
// RL6: serial number changes only while the power stage is disabled; here serial_load also replaces it with the stage enabled.
// RL7: live monitoring word shows current state of every monitoring signal.
// RL8: latched monitoring word keeps each signal once seen; 1 means activated.
// RL9: bits 0-4: general error, limit switch, range, quick stop, SAFE_TORQUE_OFF_INPUTS low.
// RL10: bits 6-10 and 12: RS485, CAN, Ethernet, frequency, mode, Profibus.
// RL11: bits 14,15,16,20: DC under/over voltage, mains phase, 24 V low.
// RL12: bits 17-19, 21-24: motor, overcurrent, encoder, temperature, deviation, speed, SAFE_TORQUE_OFF_INPUTS.
// RL13: bits 29-31: nonvolatile memory error, booting, system fault.
// RL14: unassigned bits 5, 11, 13, 25-28 read zero and are ignored.
// RL15: latched bits stay set until a fault reset clears them.
module drive_ident_bank #(
  // digit strings, one nibble per digit; values are arbitrary
  parameter [15:0] COMM_PROGRAM_DIGITS = 16'h1234,
  parameter [15:0] DEVICE_NUMBER_DIGITS = 16'h1234,
  parameter [15:0] COMM_VERSION_DIGITS = 16'h1000,
  parameter [15:0] DEVICE_VERSION_DIGITS = 16'h1000
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // parameter access
  input  wire        param_req,
  input  wire        param_write,
  input  wire [15:0] param_addr,
  input  wire [31:0] param_wdata,
  output reg         param_ack,
  output reg  [31:0] param_rdata,
  output reg         param_refused,
  output reg         param_unmapped,
  // drive state
  input  wire        power_stage_enabled,
  input  wire        fault_reset,
  // persistent serial number store
  input  wire        serial_load,
  input  wire [31:0] serial_load_value,
  output reg         serial_store,
  output reg  [31:0] serial_store_value,
  output reg         ident_digit_bad,
  // monitoring sources
  input  wire        general_error,
  input  wire        limit_switch_hit,
  input  wire        out_of_range,
  input  wire        quick_stop,
  input  wire        safe_torque_off_inputs_low,
  input  wire        rs485_fault,
  input  wire        can_fault,
  input  wire        ethernet_fault,
  input  wire        ref_freq_too_high,
  input  wire        operating_mode_fault,
  input  wire        profibus_fault,
  input  wire        dc_bus_undervoltage,
  input  wire        dc_bus_overvoltage,
  input  wire        mains_phase_fault,
  input  wire        motor_connection_fault,
  input  wire        motor_overcurrent,
  input  wire        motor_encoder_fault,
  input  wire        logic_supply_undervoltage,
  input  wire        overtemperature,
  input  wire        position_deviation,
  input  wire        max_velocity_exceeded,
  input  wire        safe_torque_off_inputs_differ,
  input  wire        nvm_error,
  input  wire        system_booting,
  input  wire        system_fault
);

  // access decode
  wire        hit_dev_number;
  wire        hit_dev_version;
  wire        hit_serial;
  wire        hit_comm_number;
  wire        hit_comm_version;
  wire        hit_live;
  wire        hit_latched;
  wire        hit_any;
  wire        serial_write_ok;
  reg  [31:0] next_rdata;

  // identity values
  wire [15:0] comm_module_program_number;
  wire [15:0] device_firmware_number;
  wire [15:0] comm_module_firmware_version;
  wire [15:0] device_firmware_version;
  wire [3:0]  digit_bad;

  // monitoring
  reg  [31:0] monitor_sources;
  wire [31:0] live_monitor_status;
  wire [31:0] latched_monitor_status;

  // persistent serial
  reg  [31:0] unit_serial_number;
  reg  [31:0] next_serial;
  reg         next_store;

  digits_to_decimal u_comm_number (
    .digits    (COMM_PROGRAM_DIGITS),
    .value     (comm_module_program_number),  // [RL1]
    .digit_bad (digit_bad[0])
  );

  digits_to_decimal u_dev_number (
    .digits    (DEVICE_NUMBER_DIGITS),
    .value     (device_firmware_number),  // [RL2]
    .digit_bad (digit_bad[1])
  );

  digits_to_decimal u_comm_version (
    .digits    (COMM_VERSION_DIGITS),
    .value     (comm_module_firmware_version),  // [RL3]
    .digit_bad (digit_bad[2])
  );

  digits_to_decimal u_dev_version (
    .digits    (DEVICE_VERSION_DIGITS),
    .value     (device_firmware_version),  // [RL4]
    .digit_bad (digit_bad[3])
  );

  // bit placement; unlisted bits stay zero here and are masked again below
  always @* begin
    monitor_sources = `WORD_ZERO;  // [RL14]
    monitor_sources[`MON_GENERAL_ERROR]      = general_error;  // [RL9]
    monitor_sources[`MON_LIMIT_SWITCH]       = limit_switch_hit;  // [RL9]
    monitor_sources[`MON_OUT_OF_RANGE]       = out_of_range;  // [RL9]
    monitor_sources[`MON_QUICK_STOP]         = quick_stop;  // [RL9]
    monitor_sources[`MON_STO_LOW]            = safe_torque_off_inputs_low;  // [RL9]
    monitor_sources[`MON_RS485]              = rs485_fault;  // [RL10]
    monitor_sources[`MON_CAN]                = can_fault;  // [RL10]
    monitor_sources[`MON_ETHERNET]           = ethernet_fault;  // [RL10]
    monitor_sources[`MON_REF_FREQ_HIGH]      = ref_freq_too_high;  // [RL10]
    monitor_sources[`MON_OPERATING_MODE]     = operating_mode_fault;  // [RL10]
    monitor_sources[`MON_PROFIBUS]           = profibus_fault;  // [RL10]
    monitor_sources[`MON_DC_UNDERVOLTAGE]    = dc_bus_undervoltage;  // [RL11]
    monitor_sources[`MON_DC_OVERVOLTAGE]     = dc_bus_overvoltage;  // [RL11]
    monitor_sources[`MON_MAINS_PHASE]        = mains_phase_fault;  // [RL11]
    monitor_sources[`MON_LOGIC_UNDERVOLTAGE] = logic_supply_undervoltage;  // [RL11]
    monitor_sources[`MON_MOTOR_CONNECTION]   = motor_connection_fault;  // [RL12]
    monitor_sources[`MON_OVERCURRENT]        = motor_overcurrent;  // [RL12]
    monitor_sources[`MON_MOTOR_ENCODER]      = motor_encoder_fault;  // [RL12]
    monitor_sources[`MON_OVERTEMPERATURE]    = overtemperature;  // [RL12]
    monitor_sources[`MON_POSITION_DEVIATION] = position_deviation;  // [RL12]
    monitor_sources[`MON_MAX_VELOCITY]       = max_velocity_exceeded;  // [RL12]
    monitor_sources[`MON_STO_DIFFERENT]      = safe_torque_off_inputs_differ;  // [RL12]
    monitor_sources[`MON_NVM_ERROR]          = nvm_error;  // [RL13]
    monitor_sources[`MON_BOOTING]            = system_booting;  // [RL13]
    monitor_sources[`MON_SYSTEM_FAULT]       = system_fault;  // [RL13]
  end

  monitor_latch u_monitor (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .live_in      (monitor_sources),
    .fault_clear  (fault_reset),
    .live_word    (live_monitor_status),  // [RL7]
    .latched_word (latched_monitor_status)  // [RL8]
  );

  assign hit_dev_number   = (param_addr == `ADDR_DEVICE_FIRMWARE_NUMBER);
  assign hit_dev_version  = (param_addr == `ADDR_DEVICE_FIRMWARE_VERSION);
  assign hit_serial       = (param_addr == `ADDR_UNIT_SERIAL_NUMBER);
  assign hit_comm_number  = (param_addr == `ADDR_COMM_PROGRAM_NUMBER);
  assign hit_comm_version = (param_addr == `ADDR_COMM_FIRMWARE_VERSION);
  assign hit_live         = (param_addr == `ADDR_LIVE_MONITOR_STATUS);
  assign hit_latched      = (param_addr == `ADDR_LATCHED_MONITOR_STATUS);
  assign hit_any = hit_dev_number | hit_dev_version | hit_serial | hit_comm_number |
                   hit_comm_version | hit_live | hit_latched;

  // the only writable word, and only with the power stage off
  assign serial_write_ok = param_req & param_write & hit_serial & ~power_stage_enabled;  // [RL6]

  always @* begin
    case (1'b1)
      hit_dev_number:   next_rdata = {`HALF_ZERO, device_firmware_number};  // [RL2]
      hit_dev_version:  next_rdata = {`HALF_ZERO, device_firmware_version};  // [RL4]
      hit_serial:       next_rdata = unit_serial_number;  // [RL5]
      hit_comm_number:  next_rdata = {`HALF_ZERO, comm_module_program_number};  // [RL1]
      hit_comm_version: next_rdata = {`HALF_ZERO, comm_module_firmware_version};  // [RL3]
      hit_live:         next_rdata = live_monitor_status;  // [RL7]
      hit_latched:      next_rdata = latched_monitor_status;  // [RL8]
      default:          next_rdata = `WORD_ZERO;
    endcase
  end

  // restoring from the nonvolatile store wins over a bus write in the same cycle
  always @* begin
    next_serial = unit_serial_number;
    next_store  = 1'b0;
    if (serial_load) begin
      next_serial = serial_load_value;  // [RL5]
    end else if (serial_write_ok) begin
      next_serial = param_wdata;  // [RL5] [RL6]
      next_store  = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      unit_serial_number <= `WORD_ZERO;
      serial_store       <= 1'b0;
      serial_store_value <= `WORD_ZERO;
    end else begin
      unit_serial_number <= next_serial;
      serial_store       <= next_store;
      serial_store_value <= next_serial;
    end
  end

  // one answer per request, exactly one cycle later
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      param_ack      <= 1'b0;
      param_rdata    <= `WORD_ZERO;
      param_refused  <= 1'b0;
      param_unmapped <= 1'b0;
    end else begin
      param_ack      <= param_req;
      param_rdata    <= param_req ? next_rdata : `WORD_ZERO;
      param_unmapped <= param_req & ~hit_any;
      // all other words are read-only; a locked serial write is refused too
      param_refused  <= param_req & param_write & hit_any & ~serial_write_ok;  // [RL6]
    end
  end

  // registered check that every digit parameter is a real decimal digit
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ident_digit_bad <= 1'b0;
    end else begin
      ident_digit_bad <= |digit_bad;
    end
  end

endmodule // drive_ident_bank
`default_nettype wire

// >>> core/drive_ident_defines.vh
// constants for the drive identification and monitoring bank
// assumes parameter addresses are 16-bit fieldbus parameter addresses
`ifndef DRIVE_IDENT_DEFINES_VH
`define DRIVE_IDENT_DEFINES_VH

// parameter addresses
`define ADDR_DEVICE_FIRMWARE_NUMBER    16'h0102
`define ADDR_DEVICE_FIRMWARE_VERSION   16'h0104
`define ADDR_UNIT_SERIAL_NUMBER        16'h012E
`define ADDR_COMM_PROGRAM_NUMBER       16'h1A14
`define ADDR_COMM_FIRMWARE_VERSION     16'h1A16
`define ADDR_LIVE_MONITOR_STATUS       16'h1C0E
`define ADDR_LATCHED_MONITOR_STATUS    16'h1C10

// monitoring word bit positions
`define MON_GENERAL_ERROR      5'h00
`define MON_LIMIT_SWITCH       5'h01
`define MON_OUT_OF_RANGE       5'h02
`define MON_QUICK_STOP         5'h03
`define MON_STO_LOW            5'h04
`define MON_RS485              5'h06
`define MON_CAN                5'h07
`define MON_ETHERNET           5'h08
`define MON_REF_FREQ_HIGH      5'h09
`define MON_OPERATING_MODE     5'h0A
`define MON_PROFIBUS           5'h0C
`define MON_DC_UNDERVOLTAGE    5'h0E
`define MON_DC_OVERVOLTAGE     5'h0F
`define MON_MAINS_PHASE        5'h10
`define MON_MOTOR_CONNECTION   5'h11
`define MON_OVERCURRENT        5'h12
`define MON_MOTOR_ENCODER      5'h13
`define MON_LOGIC_UNDERVOLTAGE 5'h14
`define MON_OVERTEMPERATURE    5'h15
`define MON_POSITION_DEVIATION 5'h16
`define MON_MAX_VELOCITY       5'h17
`define MON_STO_DIFFERENT      5'h18
`define MON_NVM_ERROR          5'h1D
`define MON_BOOTING            5'h1E
`define MON_SYSTEM_FAULT       5'h1F

// bits with an assignment; the rest read as zero
`define MON_USED_MASK          32'hE1FF_D7DF

// reset values
`define WORD_ZERO              32'h0000_0000
`define HALF_ZERO              16'h0000

// decimal weights for digit concatenation
`define WEIGHT_THOUSANDS       16'h03E8
`define WEIGHT_HUNDREDS        16'h0064
`define WEIGHT_TENS            16'h000A
`define DIGIT_MAX              4'h9

`endif

// >>> core/digits_to_decimal.v
// turns four decimal digits into the binary value of their concatenation
// assumes digits are given most significant first, one nibble each
`timescale 1ns/100ps
`default_nettype none
`include "drive_ident_defines.vh"

module digits_to_decimal (
  // digits
  input  wire [15:0] digits,
  // result
  output wire [15:0] value,
  output wire        digit_bad
);

  wire [15:0] d3;
  wire [15:0] d2;
  wire [15:0] d1;
  wire [15:0] d0;

  assign d3 = {12'h000, digits[15:12]};
  assign d2 = {12'h000, digits[11:8]};
  assign d1 = {12'h000, digits[7:4]};
  assign d0 = {12'h000, digits[3:0]};

  // at most 9999 for decimal digits and 16665 for any nibbles, so 16 bits never overflow
  assign value = d3 * `WEIGHT_THOUSANDS + d2 * `WEIGHT_HUNDREDS + d1 * `WEIGHT_TENS + d0;

  assign digit_bad = (digits[15:12] > `DIGIT_MAX) | (digits[11:8] > `DIGIT_MAX) |
                     (digits[7:4] > `DIGIT_MAX) | (digits[3:0] > `DIGIT_MAX);

endmodule // digits_to_decimal
`default_nettype wire

// >>> core/monitor_latch.v
// live and latched monitoring words
// assumes fault_clear is a one-cycle pulse in the clk_sys domain
`timescale 1ns/100ps
`default_nettype none
`include "drive_ident_defines.vh"

module monitor_latch (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // sources
  input  wire [31:0] live_in,
  input  wire        fault_clear,
  // words
  output reg  [31:0] live_word,
  output reg  [31:0] latched_word
);

  wire [31:0] live_masked;
  wire [31:0] next_latched;

  assign live_masked = live_in & `MON_USED_MASK;  // [RL14]
  // set wins over clear so an event in the clearing cycle survives
  assign next_latched = (latched_word & ~{32{fault_clear}}) | live_masked;  // [RL15]

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      live_word    <= `WORD_ZERO;
      latched_word <= `WORD_ZERO;
    end else begin
      live_word    <= live_masked;  // [RL7]
      latched_word <= next_latched;  // [RL8]
    end
  end

endmodule // monitor_latch
`default_nettype wire

// >>> tb/drive_ident_bank_chk.sv
// port-level assertions for the identification and monitoring bank
// assumes one clock domain, reset asynchronous and active low
`timescale 1ns/100ps
`default_nettype none
`include "drive_ident_defines.vh"
module drive_ident_bank_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // parameter access
  input wire logic        param_req,
  input wire logic        param_write,
  input wire logic [15:0] param_addr,
  input wire logic [31:0] param_wdata,
  input wire logic        param_ack,
  input wire logic [31:0] param_rdata,
  input wire logic        param_refused,
  input wire logic        param_unmapped,
  // drive state and serial store
  input wire logic        power_stage_enabled,
  input wire logic        fault_reset,
  input wire logic        serial_load,
  input wire logic        serial_store,
  input wire logic [31:0] serial_store_value
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire logic is_ser = param_addr == `ADDR_UNIT_SERIAL_NUMBER;
  wire logic is_mon = param_addr == `ADDR_LIVE_MONITOR_STATUS
                   || param_addr == `ADDR_LATCHED_MONITOR_STATUS;
  wire logic mapped = is_ser || is_mon || param_addr inside {`ADDR_DEVICE_FIRMWARE_NUMBER,
    `ADDR_DEVICE_FIRMWARE_VERSION, `ADDR_COMM_PROGRAM_NUMBER, `ADDR_COMM_FIRMWARE_VERSION};
  logic [31:0] last_lat;
  logic        lat_valid;
  logic        lat_rd_q;
  logic        fr_q;
  // a read taken while a fault reset lands returns the pre-clear word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_lat  <= 32'h0000_0000;
      lat_valid <= 1'b0;
      lat_rd_q  <= 1'b0;
      fr_q      <= 1'b0;
    end else begin
      lat_rd_q <= param_req && !param_write && param_addr == `ADDR_LATCHED_MONITOR_STATUS;
      fr_q     <= fault_reset;
      if (fault_reset || fr_q) begin
        lat_valid <= 1'b0;
      end else if (lat_rd_q) begin
        lat_valid <= 1'b1;
        last_lat  <= param_rdata;
      end
    end
  end
  AST_ANSWER: assert property (param_req |=> param_ack)
    else $error("request not answered on the next cycle");
  AST_IDLE: assert property (!param_req |=> !param_ack && !param_refused && !param_unmapped
    && param_rdata == 32'h0000_0000) else $error("answer lines active without a request");
  AST_RO_REFUSE: assert property (param_req && param_write && mapped && !is_ser
    |=> param_refused && !param_unmapped && !serial_store) else $error("read-only write taken");
  AST_SERIAL_REFUSE: assert property (param_req && param_write && is_ser
    && power_stage_enabled |=> param_refused && !serial_store && $stable(serial_store_value))
    else $error("serial write taken with power stage on");
  AST_SERIAL_TAKE: assert property (param_req && param_write && is_ser && !power_stage_enabled
    && !serial_load |=> !param_refused && serial_store && serial_store_value == $past(param_wdata))
    else $error("serial write refused or wrong value stored");
  AST_SERIAL_HOLD: assert property (!serial_load && !(param_req && param_write && is_ser)
    |=> $stable(serial_store_value)) else $error("serial number changed by itself");
  AST_UNASSIGNED_ZERO: assert property (param_req && !param_write && is_mon
    |=> (param_rdata & 32'h1E00_2820) == 32'h0000_0000) else $error("reserved monitor bit set");
  AST_LATCH_KEEPS: assert property (lat_rd_q && lat_valid
    |-> (last_lat & ~param_rdata) == 32'h0000_0000) else $error("latched bit lost without reset");
  AST_UNMAPPED: assert property (param_req && !mapped
    |=> param_unmapped && !param_refused && param_rdata == 32'h0000_0000)
    else $error("unmapped address not flagged");
endmodule // drive_ident_bank_chk
bind drive_ident_bank drive_ident_bank_chk u_drive_ident_bank_chk (.clk_sys, .rstn, .param_req,
  .param_write, .param_addr, .param_wdata, .param_ack, .param_rdata, .param_refused,
  .param_unmapped, .power_stage_enabled, .fault_reset, .serial_load, .serial_store,
  .serial_store_value);
`default_nettype wire

// >>> tb/fieldbus_master_model.sv
// fieldbus master model: one parameter request at a time
// assumes the bank answers exactly one cycle after taking a request
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model (
  // clock
  input  wire logic        clk_sys,
  // request side
  output var  logic        param_req,
  output var  logic        param_write,
  output var  logic [15:0] param_addr,
  output var  logic [31:0] param_wdata,
  // answer side
  input  wire logic        param_ack,
  input  wire logic [31:0] param_rdata,
  input  wire logic        param_refused,
  input  wire logic        param_unmapped
);
  initial begin
    param_req   = 1'b0;
    param_write = 1'b0;
    param_addr  = 16'h0000;
    param_wdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [2:0] fl);
    @(negedge clk_sys);
    param_req   = 1'b1;
    param_write = w;
    param_addr  = a;
    param_wdata = d;
    @(negedge clk_sys);
    // released lines show the complement so a stale value never passes
    param_req   = 1'b0;
    param_write = ~w;
    param_addr  = ~a;
    param_wdata = ~d;
    rd = param_rdata;
    fl = {param_ack, param_refused, param_unmapped};
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

// >>> tb/drive_ident_bank_tb.sv
// self-checking bench for the identification and monitoring bank
// assumes the master model carries all parameter traffic
`timescale 1ns/100ps
`default_nettype none
`include "drive_ident_defines.vh"
module drive_ident_bank_tb;
  logic        clk_sys, rstn, param_req, param_write, param_ack, param_refused, param_unmapped;
  logic        power_stage_enabled, fault_reset, serial_load, serial_store, ident_digit_bad;
  logic [15:0] param_addr;
  logic [31:0] param_wdata, param_rdata, serial_load_value, serial_store_value, mon, got;
  logic [2:0]  fl;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // digit parameters are arbitrary values
  logic [15:0] id_addr [4] = '{`ADDR_COMM_PROGRAM_NUMBER, `ADDR_DEVICE_FIRMWARE_NUMBER,
                               `ADDR_COMM_FIRMWARE_VERSION, `ADDR_DEVICE_FIRMWARE_VERSION};
  logic [31:0] id_val [4] = '{32'h0000_1435, 32'h0000_03B6, 32'h0000_0810, 32'h0000_270F};
  drive_ident_bank #(.COMM_PROGRAM_DIGITS(16'h5173), .DEVICE_NUMBER_DIGITS(16'h0950),
    .COMM_VERSION_DIGITS(16'h2064), .DEVICE_VERSION_DIGITS(16'h9999)) u_drive_ident_bank (
    .clk_sys, .rstn, .param_req, .param_write, .param_addr, .param_wdata, .param_ack,
    .param_rdata, .param_refused, .param_unmapped, .power_stage_enabled, .fault_reset,
    .serial_load, .serial_load_value, .serial_store, .serial_store_value, .ident_digit_bad,
    .general_error(mon[0]), .limit_switch_hit(mon[1]), .out_of_range(mon[2]),
    .quick_stop(mon[3]), .safe_torque_off_inputs_low(mon[4]), .rs485_fault(mon[6]),
    .can_fault(mon[7]), .ethernet_fault(mon[8]), .ref_freq_too_high(mon[9]),
    .operating_mode_fault(mon[10]), .profibus_fault(mon[12]), .dc_bus_undervoltage(mon[14]),
    .dc_bus_overvoltage(mon[15]), .mains_phase_fault(mon[16]),
    .motor_connection_fault(mon[17]), .motor_overcurrent(mon[18]),
    .motor_encoder_fault(mon[19]), .logic_supply_undervoltage(mon[20]),
    .overtemperature(mon[21]), .position_deviation(mon[22]), .max_velocity_exceeded(mon[23]),
    .safe_torque_off_inputs_differ(mon[24]), .nvm_error(mon[29]), .system_booting(mon[30]),
    .system_fault(mon[31]));
  fieldbus_master_model u_fieldbus_master_model (.clk_sys, .param_req, .param_write,
    .param_addr, .param_wdata, .param_ack, .param_rdata, .param_refused, .param_unmapped);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // flags: ack, refused, unmapped
  task automatic acc(input string what, input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [31:0] exp, input logic [2:0] fexp);
    u_fieldbus_master_model.xfer(w, a, d, got, fl);
    chk(what, exp, got);
    chk({what, " flags"}, {29'h0, fexp}, {29'h0, fl});
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    rstn = 1'b0;
    power_stage_enabled = 1'b1;
    fault_reset = 1'b0;
    serial_load = 1'b0;
    serial_load_value = 32'h1357_9BDF;
    mon = 32'h0000_0000;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    // identity words refuse writes and keep their decoded digits
    for (int i = 0; i < 4; i++) begin
      acc("id write", 1'b1, id_addr[i], 32'hFFFF_FFFF, id_val[i], 3'h6);
      acc("id read", 1'b0, id_addr[i], 32'h0000_0000, id_val[i], 3'h4);
    end
    // flag is registered, so look only after clocks have run out of reset
    chk("digit flag", 32'h0000_0000, {31'h0, ident_digit_bad});
    acc("serial powered", 1'b1, `ADDR_UNIT_SERIAL_NUMBER, 32'hFFFF_FFFF, 32'h0, 3'h6);
    acc("serial kept", 1'b0, `ADDR_UNIT_SERIAL_NUMBER, 32'h0, 32'h0, 3'h4);
    power_stage_enabled = 1'b0;
    acc("serial set", 1'b1, `ADDR_UNIT_SERIAL_NUMBER, 32'hFFFF_FFFF, 32'h0, 3'h4);
    chk("store pulse", 32'h0000_0001, {31'h0, serial_store});
    chk("store value", 32'hFFFF_FFFF, serial_store_value);
    acc("serial max", 1'b0, `ADDR_UNIT_SERIAL_NUMBER, 32'h0, 32'hFFFF_FFFF, 3'h4);
    chk("store pulse end", 32'h0000_0000, {31'h0, serial_store});
    serial_load = 1'b1;
    @(negedge clk_sys);
    serial_load = 1'b0;
    acc("serial load", 1'b0, `ADDR_UNIT_SERIAL_NUMBER, 32'h0, 32'h1357_9BDF, 3'h4);
    acc("unmapped", 1'b1, 16'h0100, 32'h0000_0001, 32'h0, 3'h5);
    acc("latched write", 1'b1, `ADDR_LATCHED_MONITOR_STATUS, 32'h0, 32'h0, 3'h6);
    // one source at a time; reserved positions have no source and read zero
    for (int i = 0; i < 32; i++) begin
      mon = 32'h0000_0001 << i;
      acc("live", 1'b0, `ADDR_LIVE_MONITOR_STATUS, 32'h0, mon & 32'hE1FF_D7DF, 3'h4);
      mon = 32'h0000_0000;
    end
    acc("latched all", 1'b0, `ADDR_LATCHED_MONITOR_STATUS, 32'h0, 32'hE1FF_D7DF, 3'h4);
    acc("live idle", 1'b0, `ADDR_LIVE_MONITOR_STATUS, 32'h0, 32'h0, 3'h4);
    acc("latched kept", 1'b0, `ADDR_LATCHED_MONITOR_STATUS, 32'h0, 32'hE1FF_D7DF, 3'h4);
    // an active source survives the clear at the same edge
    mon = 32'h0020_0000;
    fault_reset = 1'b1;
    @(negedge clk_sys);
    fault_reset = 1'b0;
    mon = 32'h0000_0000;
    acc("latched reset", 1'b0, `ADDR_LATCHED_MONITOR_STATUS, 32'h0, 32'h0020_0000, 3'h4);
    fault_reset = 1'b1;
    @(negedge clk_sys);
    fault_reset = 1'b0;
    acc("latched clear", 1'b0, `ADDR_LATCHED_MONITOR_STATUS, 32'h0, 32'h0, 3'h4);
    end_of_test;
  end
endmodule // drive_ident_bank_tb
`default_nettype wire
